// *** common/oelac_pkg.sv ***
// package for the output enable, lock and alarm control block
// assumes a single 10 MHz clock (pclk) and an apb register slave
package oelac_pkg;

	// ************************************************************
	// clock and timing
	// ************************************************************
	localparam int unsigned CLK_HZ          = 10_000_000;
	localparam int unsigned ACK_LOW_MS      = 50;
	// least time, no rounding (the added term is 0)
	localparam int unsigned ACK_LOW_CYCLES  = (ACK_LOW_MS * (CLK_HZ / 1000) + 0) ;
	localparam int unsigned DEBOUNCE_US     = 1000;
	localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_US * (CLK_HZ / 1_000_000);

	// ************************************************************
	// alarm indices
	// ************************************************************
	localparam int unsigned NUM_ALARMS = 5;
	localparam int unsigned AL_OT      = 0;
	localparam int unsigned AL_PF      = 1;
	localparam int unsigned AL_OV      = 2;
	localparam int unsigned AL_OC      = 3;
	localparam int unsigned AL_OP      = 4;
	// alarms that clear themselves once the cause is gone
	localparam logic [4:0]  SELF_CLEAR = 5'h03;

	// ************************************************************
	// register offsets (byte addresses)
	// ************************************************************
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_CMD     = 8'h04;
	localparam logic [7:0] REG_STATUS  = 8'h08;
	localparam logic [7:0] REG_ALARM   = 8'h0C;
	localparam logic [7:0] REG_HIST0   = 8'h10;

	// ctrl fields
	localparam int unsigned CTRL_INVERT = 0;
	localparam int unsigned CTRL_BUZZEN = 1;
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;

	// cmd fields (write one to fire)
	localparam int unsigned CMD_ON  = 0;
	localparam int unsigned CMD_OFF = 1;
	localparam int unsigned CMD_ACK = 2;

	// status fields
	localparam int unsigned ST_OUT_ON  = 0;
	localparam int unsigned ST_LOCKED  = 1;
	localparam int unsigned ST_REMOTE  = 2;
	localparam int unsigned ST_PIN     = 3;
	localparam int unsigned ST_ERR     = 4;
	localparam int unsigned ST_PENDING = 5;

	localparam int unsigned HIST_W = 16;

endpackage

// *** verilog/oelac_filter.sv ***
// two-flop synchroniser with a stable-count debounce filter
// assumes the input is asynchronous and may bounce
`timescale 1ns/1ps
module oelac_filter #(
	parameter int unsigned CYCLES = 10_000,
	parameter logic        RESET_LEVEL = 1'b1
) (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// raw and filtered level
	input  wire logic raw,
	output logic      level
);
	localparam int unsigned CW = $clog2(CYCLES + 1);

	logic          sync1;
	logic          sync2;
	logic [CW-1:0] count;
	wire           differs   = (sync2 != level);
	wire           count_end = (count == CW'(CYCLES - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= RESET_LEVEL;
			sync2 <= RESET_LEVEL;
		end else begin
			sync1 <= raw;
			sync2 <= sync1;
		end
	end

	// any bounce restarts the stable count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
			level <= RESET_LEVEL;
		end else if (!differs) begin
			count <= '0;
		end else if (count_end) begin
			count <= '0;
			level <= sync2;
		end else begin
			count <= count + CW'(1);
		end
	end
endmodule

// *** verilog/oelac_top.sv ***
// output enable, lock and alarm control with apb register slave
// assumes pins arrive raw (filtered here) and alarm causes are synchronous levels
`timescale 1ns/1ps
module oelac_top
	import oelac_pkg::*;
#(
	parameter int unsigned ACK_CYCLES = ACK_LOW_CYCLES,
	parameter int unsigned DEB_CYCLES = DEBOUNCE_CYCLES
) (
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// analog interface pins
	input  wire logic        output_standby_pin,
	input  wire logic        remote_select_n,
	output logic             alarm_out1,
	output logic             alarm_out2,
	// front panel and alarm causes
	input  wire logic        button_onoff,
	input  wire logic        button_ack,
	input  wire logic        overtemperature_alarm,
	input  wire logic        supply_failure_alarm,
	input  wire logic        overvoltage_alarm,
	input  wire logic        overcurrent_alarm,
	input  wire logic        overpower_alarm,
	// power stage and indication
	output logic             dc_output_on,
	output logic             buzzer
);
	localparam int unsigned ACW = $clog2(ACK_CYCLES + 1);

	// ************************************************************
	// pin conditioning
	// ************************************************************
	logic pin_level;
	logic remote_level_n;

	oelac_filter #(.CYCLES(DEB_CYCLES), .RESET_LEVEL(1'b1)) u_sb_filt (
		.pclk    (pclk),
		.presetn (presetn),
		.raw     (output_standby_pin),
		.level   (pin_level)
	);

	oelac_filter #(.CYCLES(DEB_CYCLES), .RESET_LEVEL(1'b1)) u_rem_filt (
		.pclk    (pclk),
		.presetn (presetn),
		.raw     (remote_select_n),
		.level   (remote_level_n)
	);

	// ************************************************************
	// registers and state
	// ************************************************************
	logic [31:0]       ctrl;
	logic              out_on;
	logic              pend_on;
	logic              err_flag;
	logic              pin_on_q;
	logic              button_q;
	logic              ack_btn_q;
	logic [4:0]        alarm_lat;
	logic [4:0]        cause_q;
	logic [HIST_W-1:0] hist [NUM_ALARMS];
	logic [ACW-1:0]    low_count;
	logic              low_long;

	// ************************************************************
	// decode
	// ************************************************************
	wire         apb_acc  = psel & penable;
	wire         apb_wr   = apb_acc & pwrite;
	wire         cmd_wr   = apb_wr & (paddr == REG_CMD);
	wire         ctrl_wr  = apb_wr & (paddr == REG_CTRL);
	wire         hist_hit = (paddr >= REG_HIST0) && (paddr < REG_HIST0 + 8'(4 * NUM_ALARMS));
	wire [2:0]   hist_idx = 3'((paddr - REG_HIST0) >> 2);
	wire         map_hit  = (paddr == REG_CTRL) | (paddr == REG_CMD) | (paddr == REG_STATUS)
	                        | (paddr == REG_ALARM) | hist_hit;
	wire         aligned  = (paddr[1:0] == 2'b00);

	wire         pin_on    = pin_level ^ ctrl[CTRL_INVERT];
	wire         remote    = ~remote_level_n;
	wire         press     = button_onoff & ~button_q;
	wire         ack_press = button_ack & ~ack_btn_q;
	wire         req_on    = (cmd_wr & pwdata[CMD_ON]) | (press & ~out_on);
	wire         req_off   = (cmd_wr & pwdata[CMD_OFF]) | (press & out_on);
	wire [4:0]   cause     = {overpower_alarm, overcurrent_alarm, overvoltage_alarm,
	                          supply_failure_alarm, overtemperature_alarm};
	wire         any_alarm = |alarm_lat;
	wire         new_alarm = |(cause & ~cause_q);
	// pulse ends with low phase long enough
	wire         pin_ack   = remote & pin_on & ~pin_on_q & low_long;
	wire         ack       = (cmd_wr & pwdata[CMD_ACK]) | ack_press | pin_ack;
	wire         locked    = ~remote & ~pin_on & ~out_on;

	// ack clears only vanished causes; self-clearing ones
	wire [4:0]   clr_mask  = (~cause & SELF_CLEAR) | (ack ? ~cause : 5'h00);
	wire [4:0]   next_lat  = cause | (alarm_lat & ~clr_mask);

	logic next_on;
	logic next_pend;
	always_comb begin
		next_on   = out_on;
		next_pend = pend_on;
		if (new_alarm || any_alarm) begin
			next_on   = 1'b0;
			next_pend = 1'b0;
		end else if (remote) begin
			next_on   = pin_on;
			next_pend = 1'b0;
		end else if (out_on) begin
			if (!pin_on) begin
				next_on   = 1'b0;
				next_pend = 1'b1;
			end else if (req_off) begin
				next_on = 1'b0;
			end
		end else if (pin_on) begin
			if (pend_on && !pin_on_q) begin
				next_on   = 1'b1;
				next_pend = 1'b0;
			end else if (req_on) begin
				next_on   = 1'b1;
				next_pend = 1'b0;
			end
		end else if (req_on || req_off) begin
			next_pend = 1'b0;
		end
	end

	// ************************************************************
	// output and lock state
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_on    <= 1'b0;
			pend_on   <= 1'b0;
			pin_on_q  <= 1'b1;
			button_q  <= 1'b0;
			ack_btn_q <= 1'b0;
			cause_q   <= 5'h00;
			alarm_lat <= 5'h00;
		end else begin
			out_on    <= next_on;
			pend_on   <= next_pend;
			pin_on_q  <= pin_on;
			button_q  <= button_onoff;
			ack_btn_q <= button_ack;
			cause_q   <= cause;
			alarm_lat <= next_lat;
		end
	end

	// locked refuses; error flag, set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_flag <= 1'b0;
		end else if (locked && req_on) begin
			err_flag <= 1'b1;
		end else if (cmd_wr && pwdata[CMD_ACK]) begin
			err_flag <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_count <= '0;
			low_long  <= 1'b0;
		end else if (pin_on) begin
			low_count <= '0;
			low_long  <= 1'b0;
		end else if (low_count == ACW'(ACK_CYCLES - 1)) begin
			low_long <= 1'b1;
		end else begin
			low_count <= low_count + ACW'(1);
		end
	end

	// ************************************************************
	// alarm history
	// ************************************************************
	// counters cleared only by power-on reset
	genvar g;
	generate
		for (g = 0; g < NUM_ALARMS; g++) begin : g_hist
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					hist[g] <= '0;
				end else if (cause[g] && !cause_q[g] && hist[g] != '1) begin
					hist[g] <= hist[g] + HIST_W'(1);
				end
			end
		end
	endgenerate

	// ************************************************************
	// apb slave and outputs
	// ************************************************************
	wire [31:0] status_word = {26'h000_0000, pend_on, err_flag, pin_level, remote, locked, out_on};
	wire [31:0] hist_word   = hist_hit ? {{(32 - HIST_W){1'b0}}, hist[hist_idx]} : 32'h0000_0000;
	wire [31:0] read_word   = (paddr == REG_CTRL)   ? ctrl :
	                          (paddr == REG_STATUS) ? status_word :
	                          (paddr == REG_ALARM)  ? {22'h00_0000, cause, alarm_lat} :
	                          hist_word;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RESET;
		end else if (ctrl_wr && aligned) begin
			ctrl <= {30'h0000_0000, pwdata[1:0]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata     <= 32'h0000_0000;
			dc_output_on <= 1'b0;
			alarm_out1 <= 1'b0;
			alarm_out2 <= 1'b0;
			buzzer     <= 1'b0;
		end else begin
			prdata       <= (psel && !penable && !pwrite) ? read_word : prdata;
			dc_output_on <= next_on;
			alarm_out1   <= next_lat[AL_OT] | next_lat[AL_PF];
			alarm_out2   <= next_lat[AL_OV] | next_lat[AL_OC] | next_lat[AL_OP];
			buzzer       <= (|next_lat) & ctrl[CTRL_BUZZEN];
		end
	end

	assign pready  = 1'b1;
	assign pslverr = apb_acc & ~(map_hit & aligned);
endmodule

// *** test/oelac_top_assertions.sv ***
// checker for the output enable, lock and alarm block, top ports only
// assumes one clock domain and a bind into every oelac_top
`timescale 1ns/1ps
module oelac_chk (
	// clock and apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// alarms and output
	input wire logic overtemperature_alarm,
	input wire logic supply_failure_alarm,
	input wire logic overvoltage_alarm,
	input wire logic alarm_out1,
	input wire logic alarm_out2,
	input wire logic dc_output_on,
	input wire logic buzzer
);
	// ************************************************************
	// properties
	// ************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_ov_rise; $rose(overvoltage_alarm); endsequence
	sequence s_ov_held; overvoltage_alarm && alarm_out2; endsequence
	sequence s_grp1_gone; (!overtemperature_alarm && !supply_failure_alarm) [*4]; endsequence
	property p_ready; psel && penable |-> pready; endproperty
	property p_slverr; pslverr |-> psel && penable; endproperty
	property p_ov_al2; s_ov_rise |-> ##[1:3] alarm_out2; endproperty
	property p_ov_hold; s_ov_held |=> alarm_out2; endproperty
	property p_ov_off; overvoltage_alarm [*3] |-> !dc_output_on; endproperty
	property p_ot_al1; $rose(overtemperature_alarm) |-> ##[1:3] alarm_out1; endproperty
	property p_al1_low; s_grp1_gone |-> !alarm_out1; endproperty
	property p_buz; buzzer |-> alarm_out1 || alarm_out2; endproperty
	a_ready: assert property (p_ready) else $error("access without ready");
	a_slverr: assert property (p_slverr) else $error("error outside access");
	a_ov_al2: assert property (p_ov_al2) else $error("alarm two missing");
	a_ov_hold: assert property (p_ov_hold) else $error("alarm two dropped");
	a_ov_off: assert property (p_ov_off) else $error("output on in alarm");
	a_ot_al1: assert property (p_ot_al1) else $error("alarm one missing");
	a_al1_low: assert property (p_al1_low) else $error("alarm one stuck");
	a_buz: assert property (p_buz) else $error("buzzer without alarm");
endmodule

bind oelac_top oelac_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
	.overtemperature_alarm, .supply_failure_alarm, .overvoltage_alarm, .alarm_out1,
	.alarm_out2, .dc_output_on, .buzzer);

// *** test/oelac_contact.sv ***
// model of the external contact on the standby and remote-select pins
// assumes the pins are pulled high inside the device when left open
`timescale 1ns/1ps
module oelac_contact (
	// clock
	input  wire logic pclk,
	// driven pins
	output logic      output_standby_pin,
	output logic      remote_select_n
);
	// ************************************************************
	// contact state
	// ************************************************************
	logic closed = 1'b0;
	logic remote = 1'b0;
	assign output_standby_pin = !closed;
	assign remote_select_n = !remote;
	// one bounce on every standby contact change, as real contacts do; remote select changes cleanly
	task automatic set_closed(input logic c);
		@(posedge pclk) closed <= c;
		@(posedge pclk) closed <= !c;
		@(posedge pclk) closed <= c;
	endtask
	task automatic set_remote(input logic r);
		@(posedge pclk) remote <= r;
	endtask
	task automatic ack_pulse(input int low);
		set_closed(1'b1);
		repeat (low) @(posedge pclk);
		set_closed(1'b0);
	endtask
endmodule

// *** test/tb_top.sv ***
// self-checking bench for the output enable, lock and alarm block
// assumes short filter and acknowledge counts, set through parameters
`timescale 1ns/1ps
module tb_top;
	import oelac_pkg::*;
	// ************************************************************
	// signals and instances
	// ************************************************************
	localparam int unsigned ACK    = 8;
	localparam logic [31:0] C_NONE = 32'h0000_0000;
	localparam logic [31:0] C_ON   = 32'h0000_0001;
	localparam logic [31:0] C_OFF  = 32'h0000_0002;
	localparam logic [31:0] C_ACK  = 32'h0000_0004;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic        pready, pslverr, err, output_standby_pin, remote_select_n, alarm_out1;
	logic        alarm_out2, dc_output_on, buzzer, button_onoff = 1'b0, button_ack = 1'b0;
	logic        overtemperature_alarm = 1'b0, supply_failure_alarm = 1'b0;
	logic        overvoltage_alarm = 1'b0, overcurrent_alarm = 1'b0, overpower_alarm = 1'b0;
	int          fail_count = 0, samples_checked = 0;
	oelac_top #(.ACK_CYCLES(ACK), .DEB_CYCLES(4)) dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .output_standby_pin,
		.remote_select_n, .alarm_out1, .alarm_out2, .button_onoff, .button_ack,
		.overtemperature_alarm, .supply_failure_alarm, .overvoltage_alarm,
		.overcurrent_alarm, .overpower_alarm, .dc_output_on, .buzzer);
	oelac_contact pt (.pclk, .output_standby_pin, .remote_select_n);
	initial forever #50 pclk = ~pclk;
	// ************************************************************
	// tasks
	// ************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic stuck();
		fail_count++;
		finish_test();
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			if (++n > 20) stuck();
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cmd(input logic [31:0] c);
		apb(1'b1, REG_CMD, c);
	endtask
	task automatic st(input logic [31:0] exp);
		apb(1'b0, REG_STATUS, C_NONE);
		check(rd & 32'h0000_003F, exp);
	endtask
	task automatic idle();
		repeat (14) @(posedge pclk);
	endtask
	task automatic hold(input logic exp);
		idle();
		check(dc_output_on, exp);
	endtask
	task automatic wait_dc(input logic exp);
		int n;
		n = 0;
		while (dc_output_on !== exp) begin
			if (++n > 60) stuck();
			@(posedge pclk);
		end
		check(dc_output_on, exp);
	endtask
	// ************************************************************
	// sequence
	// ************************************************************
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, REG_CTRL, C_NONE);
		check(rd, CTRL_RESET);
		apb(1'b0, 8'h40, C_NONE);
		check({rd[30:0], err}, 32'h0000_0001);
		apb(1'b1, REG_STATUS, 32'hFFFF_FFFF);
		st(32'h0000_0008);
		cmd(C_ON);
		wait_dc(1'b1);
		pt.set_closed(1'b1);
		check(dc_output_on, 1'b1);
		wait_dc(1'b0);
		st(32'h0000_0022);
		pt.set_closed(1'b0);
		wait_dc(1'b1);
		pt.set_closed(1'b1);
		wait_dc(1'b0);
		cmd(C_ON);
		st(32'h0000_0012);
		pt.set_closed(1'b0);
		hold(1'b0);
		cmd(C_ACK);
		st(32'h0000_0008);
		// polarity inverted: open pin now means off
		apb(1'b1, REG_CTRL, C_ON);
		cmd(C_ON);
		hold(1'b0);
		st(32'h0000_001A);
		cmd(C_ACK);
		pt.set_closed(1'b1);
		idle();
		cmd(C_ON);
		wait_dc(1'b1);
		cmd(C_OFF);
		wait_dc(1'b0);
		pt.set_closed(1'b0);
		apb(1'b1, REG_CTRL, C_NONE);
		idle();
		pt.set_remote(1'b1);
		wait_dc(1'b1);
		st(32'h0000_000D);
		cmd(C_OFF);
		button_onoff <= 1'b1;
		idle();
		button_onoff <= 1'b0;
		hold(1'b1);
		pt.set_closed(1'b1);
		wait_dc(1'b0);
		pt.set_closed(1'b0);
		wait_dc(1'b1);
		overvoltage_alarm <= 1'b1;
		wait_dc(1'b0);
		check(alarm_out2, 1'b1);
		pt.ack_pulse(ACK + 4);
		hold(1'b0);
		overvoltage_alarm <= 1'b0;
		hold(1'b0);
		check(alarm_out2, 1'b1);
		pt.ack_pulse(ACK + 4);
		wait_dc(1'b1);
		check(alarm_out2, 1'b0);
		apb(1'b1, REG_CTRL, C_OFF);
		overtemperature_alarm <= 1'b1;
		wait_dc(1'b0);
		check({alarm_out1, buzzer}, 2'h3);
		overtemperature_alarm <= 1'b0;
		wait_dc(1'b1);
		check({alarm_out1, buzzer}, 2'h0);
		apb(1'b1, REG_CTRL, C_NONE);
		supply_failure_alarm <= 1'b1;
		wait_dc(1'b0);
		check({alarm_out1, buzzer}, 2'h2);
		supply_failure_alarm <= 1'b0;
		wait_dc(1'b1);
		// button acknowledge refused while the cause stands
		overcurrent_alarm <= 1'b1;
		wait_dc(1'b0);
		check(alarm_out2, 1'b1);
		button_ack <= 1'b1;
		idle();
		button_ack <= 1'b0;
		overcurrent_alarm <= 1'b0;
		hold(1'b0);
		check(alarm_out2, 1'b1);
		button_ack <= 1'b1;
		wait_dc(1'b1);
		check(alarm_out2, 1'b0);
		button_ack <= 1'b0;
		// register acknowledge, first too early, then after the cause
		overpower_alarm <= 1'b1;
		wait_dc(1'b0);
		cmd(C_ACK);
		hold(1'b0);
		check({alarm_out2, buzzer}, 2'h2);
		overpower_alarm <= 1'b0;
		cmd(C_ACK);
		wait_dc(1'b1);
		check(alarm_out2, 1'b0);
		// every alarm type rose exactly once
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, REG_HIST0 + 8'(4 * i), C_NONE);
			check(rd, 32'h0000_0001);
		end
		// power cycle: history starts from zero again
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, REG_HIST0, C_NONE);
		check(rd, C_NONE);
		wait_dc(1'b1);
		finish_test();
	end
endmodule
